// [xra_cfg.svh]
// constants for the data-move decoder and nonvolatile store
`ifndef XRA_CFG_SVH
`define XRA_CFG_SVH
`define XRA_PAGE_SEL_ADDR 8'hf6
`define XRA_NV_CTL_ADDR 8'hd2
`define XRA_AUX_CTL_ADDR 8'h8e
`define XRA_CTL_BUSY 0
`define XRA_CTL_MAP 1
`define XRA_CTL_ERR 2
`define XRA_CTL_INHIBIT 3
`define XRA_CTL_PGLOAD 5
`define XRA_AUX_BYPASS 1
`define XRA_AUX_SIZE_LSB 2
`define XRA_PAGE_RST 8'h00
`define XRA_AUX_RST 8'h08
`define XRA_RAM_TOP 16'h07ff
`define XRA_NV_TOP 16'h0fff
`define XRA_NARROW_PAGES 8'h08
`define XRA_PAGE_BYTES 32
`define XRA_NV_BYTES 4096
`define XRA_RAM_BYTES 2048
`define XRA_LOCKOUT_MS 2
`define XRA_PROG_MS 4
`define XRA_CLK_KHZ 40000
`define XRA_REFUSED_DATA 8'hff
`endif

// [xra_pkg.sv]
// types shared by both ends of the data-move link
package xra_pkg;
  typedef enum logic [1:0] {OP_MOVE, OP_SFR, OP_NV_RD, OP_NV_WR} xra_op_e;
  typedef enum {TG_RAM, TG_NV, TG_EXT} xra_tgt_e;
  typedef enum {ST_IDLE, ST_WAIT, ST_NVRD, ST_EXT} xra_dev_st_e;
  typedef enum {H_IDLE, H_RAW, H_POLL, H_MAP, H_MOVE, H_UNMAP} xra_cpu_st_e;
endpackage : xra_pkg

// [xra_if.sv]
// link between cpu core and data-move decoder
`timescale 1ns/1ps
interface xra_if;
  logic mv_req;
  logic mv_wr;
  logic mv_wide;
  logic [15:0] mv_addr;
  logic [7:0] mv_wdata;
  logic mv_ack;
  logic [7:0] mv_rdata;
  logic sfr_req;
  logic sfr_wr;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_ack;
  logic [7:0] sfr_rdata;
  modport dev (input mv_req, mv_wr, mv_wide, mv_addr, mv_wdata, sfr_req, sfr_wr, sfr_addr, sfr_wdata,
               output mv_ack, mv_rdata, sfr_ack, sfr_rdata);
  modport cpu (output mv_req, mv_wr, mv_wide, mv_addr, mv_wdata, sfr_req, sfr_wr, sfr_addr, sfr_wdata,
               input mv_ack, mv_rdata, sfr_ack, sfr_rdata);
endinterface : xra_if

// [xra_nv_core.sv]
// nonvolatile array with page buffer and program timer
`timescale 1ns/1ps
`include "xra_cfg.svh"
module xra_nv_core #(
  parameter int unsigned DEPTH = `XRA_NV_BYTES,
  parameter int unsigned PAGE_BYTES = `XRA_PAGE_BYTES,
  parameter int unsigned PROG_CYC = `XRA_PROG_MS * `XRA_CLK_KHZ
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic [11:0] rd_addr, // read address
  output logic [7:0] rd_data, // read byte, one cycle late
  input wire logic ld_en, // store byte into page buffer
  input wire logic [11:0] ld_addr, // byte address of load
  input wire logic [7:0] ld_data, // byte to load
  input wire logic start, // program buffered bytes
  input wire logic discard, // drop buffered bytes
  input wire logic abort, // brownout seen
  output logic busy, // programming in progress
  output logic fail // pulse: program cut short
);
  import xra_pkg::*;
  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [6:0] page_reg;
  logic [23:0] timer_reg;
  logic committing_reg;
  logic [4:0] walk_reg;

  // array read, no reset so it maps to memory
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

  // page buffer data
  always_ff @(posedge clk) begin
    if (ld_en && !busy) begin
      pbuf[ld_addr[4:0]] <= ld_data;
    end
  end

  // one location per cycle, erase and program as one step
  always_ff @(posedge clk) begin
    if (committing_reg && mask_reg[walk_reg]) begin
      mem[{page_reg, walk_reg}] <= pbuf[walk_reg];
    end
  end

  // sequencing; commit waits the full time so an early brownout leaves the array clean
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {busy, fail, committing_reg} <= 3'h0;
      mask_reg <= '0;
      page_reg <= '0;
      timer_reg <= '0;
      walk_reg <= '0;
    end else begin
      fail <= 1'b0;
      if (busy) begin
        if (abort) begin
          busy <= 1'b0;
          fail <= 1'b1;
          committing_reg <= 1'b0;
          mask_reg <= '0;
        end else if (committing_reg) begin
          walk_reg <= walk_reg + 5'h01;
          if (walk_reg == 5'h1f) begin
            committing_reg <= 1'b0;
            busy <= 1'b0;
            mask_reg <= '0;
          end
        end else if (timer_reg == 24'h000001) begin
          committing_reg <= 1'b1;
          walk_reg <= 5'h00;
        end else begin
          timer_reg <= timer_reg - 24'h000001;
        end
      end else if (discard) begin
        mask_reg <= '0;
      end else if (ld_en) begin
        mask_reg[ld_addr[4:0]] <= 1'b1;
        if (start) begin
          busy <= 1'b1;
          page_reg <= ld_addr[11:5];
          timer_reg <= 24'(PROG_CYC);
        end
      end
    end
  end
endmodule : xra_nv_core

// [xra_device.sv]
// data-move decoder: aux ram, nonvolatile store and external bus routing
// Contract
// - bypass off: 0000H-07FFH to aux RAM, sized
// - narrow moves take upper bits from page
// - page 00-07 picks ram page, else external
// - one page value for both pointers
// - wide moves reach RAM only when unmapped
// - aux RAM moves take at least 2 cycles
// - mapped store at 0000H-0FFFH, else hidden
// - store reachable only by wide moves
// - mapped: above store range goes external
// - software polls busy, maps, reads, unmaps
// - software masks interrupts around store access
// - cpu runs on; busy flag shows completion
// - byte write erases then programs atomically
// - no write within 2 ms of brownout
// - brownout during program sets error flag
// - software awaits lockout release, then busy low
// - byte write: map, move, unmap
// - busy set on write, blocks access, self-clears
// - page-load mode only fills page buffer
// - final write programs all, sets page
// - 32-byte buffer; unloaded bytes untouched
// - software keeps page bytes unique, one page
// - bypass sends all 64KB external
// - error flag stays until software clears
`timescale 1ns/1ps
`include "xra_cfg.svh"
module xra_device #(
  parameter int unsigned LOCKOUT_CYC = `XRA_LOCKOUT_MS * `XRA_CLK_KHZ,
  parameter int unsigned PROG_CYC = `XRA_PROG_MS * `XRA_CLK_KHZ
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  xra_if.dev cpu, // cpu core side
  input wire logic brownout, // brownout detector, asynchronous
  output logic ext_req, // external bus request
  output logic ext_wr, // external write
  output logic ext_hi_en, // high address byte valid
  output logic [15:0] ext_addr, // external address
  output logic [7:0] ext_wdata, // external write data
  input wire logic ext_ack, // external bus done
  input wire logic [7:0] ext_rdata // external read data
);
  import xra_pkg::*;
  logic [7:0] page_reg;
  logic bypass_reg, map_reg, pgload_reg, err_reg;
  logic [2:0] size_reg;
  logic bo_s1, bo_s2, bo_s3, bo_lvl;
  logic [23:0] lock_reg;
  logic write_ok;
  logic [7:0] ram [0:`XRA_RAM_BYTES-1];
  logic [7:0] hold_reg;
  xra_dev_st_e st_reg;
  xra_tgt_e tgt;
  logic [15:0] eff_addr;
  logic in_ram, take;
  logic nv_busy, nv_fail;
  logic [7:0] nv_rd;
  logic nv_ld, nv_start, nv_discard;

  // usable ram pages per size code; reserved codes keep the full 2 KB
  function automatic logic [3:0] ram_pages(input logic [2:0] sz);
    ram_pages = (sz == 3'h4) ? 4'h7 : (sz > 3'h4) ? 4'h8 : {1'b0, sz} + 4'h1;
  endfunction : ram_pages

  // brownout pin: three stages, level moves when last two agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {bo_s1, bo_s2, bo_s3, bo_lvl} <= 4'h0;
    end else begin
      bo_s1 <= brownout;
      bo_s2 <= bo_s1;
      bo_s3 <= bo_s2;
      if (bo_s2 == bo_s3) begin
        bo_lvl <= bo_s3;
      end
    end
  end

  // write lockout; reset counts as a brownout so early writes are held off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= 24'(LOCKOUT_CYC);
    end else if (bo_lvl) begin
      lock_reg <= 24'(LOCKOUT_CYC);
    end else if (lock_reg != 24'h000000) begin
      lock_reg <= lock_reg - 24'h000001;
    end
  end
  assign write_ok = (lock_reg == 24'h000000) && !bo_lvl;

  // special-function registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_reg <= `XRA_PAGE_RST;
      bypass_reg <= 1'(`XRA_AUX_RST >> `XRA_AUX_BYPASS);
      size_reg <= 3'(`XRA_AUX_RST >> `XRA_AUX_SIZE_LSB);
      {map_reg, pgload_reg, err_reg} <= 3'h0;
    end else begin
      if (cpu.sfr_req && cpu.sfr_wr && cpu.sfr_addr == `XRA_PAGE_SEL_ADDR) begin
        page_reg <= cpu.sfr_wdata;
      end
      if (cpu.sfr_req && cpu.sfr_wr && cpu.sfr_addr == `XRA_AUX_CTL_ADDR) begin
        bypass_reg <= cpu.sfr_wdata[`XRA_AUX_BYPASS];
        size_reg <= cpu.sfr_wdata[`XRA_AUX_SIZE_LSB +: 3];
      end
      if (cpu.sfr_req && cpu.sfr_wr && cpu.sfr_addr == `XRA_NV_CTL_ADDR) begin
        map_reg <= cpu.sfr_wdata[`XRA_CTL_MAP];
        pgload_reg <= cpu.sfr_wdata[`XRA_CTL_PGLOAD];
        err_reg <= err_reg && cpu.sfr_wdata[`XRA_CTL_ERR];
      end
      // a failure in the same cycle as a clear keeps the flag
      if (nv_fail) begin
        err_reg <= 1'b1;
      end
    end
  end

  // register read-back, one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu.sfr_ack <= 1'b0;
      cpu.sfr_rdata <= 8'h00;
    end else begin
      cpu.sfr_ack <= cpu.sfr_req;
      if (cpu.sfr_req) begin
        case (cpu.sfr_addr)
          `XRA_PAGE_SEL_ADDR: cpu.sfr_rdata <= page_reg;
          `XRA_AUX_CTL_ADDR: cpu.sfr_rdata <= {3'h0, size_reg, bypass_reg, 1'b0};
          `XRA_NV_CTL_ADDR: cpu.sfr_rdata <= {1'b1, 1'b0, pgload_reg, 1'b0, write_ok, err_reg, map_reg, nv_busy};
          default: cpu.sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  // target decode for the move offered this cycle
  always_comb begin
    tgt = TG_EXT;
    eff_addr = cpu.mv_addr;
    if (!cpu.mv_wide) begin
      eff_addr = {5'h00, page_reg[2:0], cpu.mv_addr[7:0]};
    end
    in_ram = (eff_addr <= `XRA_RAM_TOP) && ({1'b0, eff_addr[10:8]} < ram_pages(size_reg));
    if (bypass_reg) begin
      tgt = TG_EXT;
    end else if (!cpu.mv_wide) begin
      if (page_reg < `XRA_NARROW_PAGES && in_ram) begin
        tgt = TG_RAM;
      end
    end else if (map_reg) begin
      if (cpu.mv_addr <= `XRA_NV_TOP) begin
        tgt = TG_NV;
      end
    end else if (in_ram) begin
      tgt = TG_RAM;
    end
  end

  assign take = (st_reg == ST_IDLE) && cpu.mv_req;
  // busy refuses load and program; the core latches the page
  assign nv_ld = take && tgt == TG_NV && cpu.mv_wr && !nv_busy && (pgload_reg || write_ok);
  assign nv_start = nv_ld && !pgload_reg;
  assign nv_discard = take && tgt == TG_NV && cpu.mv_wr && !nv_busy && !pgload_reg && !write_ok;

  // aux ram array, no reset
  always_ff @(posedge clk) begin
    if (take && tgt == TG_RAM) begin
      if (cpu.mv_wr) begin
        ram[eff_addr[10:0]] <= cpu.mv_wdata;
      end else begin
        hold_reg <= ram[eff_addr[10:0]];
      end
    end else if (take && tgt == TG_NV) begin
      hold_reg <= `XRA_REFUSED_DATA;
    end
  end

  // move sequencer: internal accesses answer two cycles after the take
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      cpu.mv_ack <= 1'b0;
      cpu.mv_rdata <= 8'h00;
    end else begin
      cpu.mv_ack <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (cpu.mv_req) begin
            if (tgt == TG_EXT) begin
              st_reg <= ST_EXT;
            end else if (tgt == TG_NV && !cpu.mv_wr && !nv_busy) begin
              st_reg <= ST_NVRD;
            end else begin
              st_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          cpu.mv_ack <= 1'b1;
          cpu.mv_rdata <= hold_reg;
          st_reg <= ST_IDLE;
        end
        ST_NVRD: begin
          cpu.mv_ack <= 1'b1;
          cpu.mv_rdata <= nv_rd;
          st_reg <= ST_IDLE;
        end
        ST_EXT: begin
          if (ext_ack) begin
            cpu.mv_ack <= 1'b1;
            cpu.mv_rdata <= ext_rdata;
            st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // external bus; narrow moves drive the high byte as 00 with ext_hi_en low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {ext_req, ext_wr, ext_hi_en} <= 3'h0;
      ext_addr <= 16'h0000;
      ext_wdata <= 8'h00;
    end else if (take && tgt == TG_EXT) begin
      ext_req <= 1'b1;
      ext_wr <= cpu.mv_wr;
      ext_hi_en <= cpu.mv_wide;
      ext_addr <= cpu.mv_wide ? cpu.mv_addr : {8'h00, cpu.mv_addr[7:0]};
      ext_wdata <= cpu.mv_wdata;
    end else if (ext_ack) begin
      ext_req <= 1'b0;
    end
  end

  xra_nv_core #(.PROG_CYC(PROG_CYC)) u_nv (
    .clk(clk),
    .sys_rst(sys_rst),
    .rd_addr(cpu.mv_addr[11:0]),
    .rd_data(nv_rd),
    .ld_en(nv_ld),
    .ld_addr(cpu.mv_addr[11:0]),
    .ld_data(cpu.mv_wdata),
    .start(nv_start),
    .discard(nv_discard),
    .abort(bo_lvl),
    .busy(nv_busy),
    .fail(nv_fail)
  );
endmodule : xra_device

// [xra_cpu_end.sv]
// cpu-side end: raw moves and the store read/write sequences
`timescale 1ns/1ps
`include "xra_cfg.svh"
module xra_cpu_end (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  xra_if.cpu dev, // decoder side
  input wire logic cmd_valid, // command offered
  input wire xra_pkg::xra_op_e cmd_op, // command kind
  input wire logic cmd_wr, // write for raw commands
  input wire logic cmd_wide, // wide pointer for raw moves
  input wire logic [15:0] cmd_addr, // address
  input wire logic [7:0] cmd_data, // write data
  output logic cmd_ready, // idle, command taken
  output logic rsp_valid, // pulse: command done
  output logic [7:0] rsp_data, // read data
  output logic irq_hold // mask interrupts while high
);
  import xra_pkg::*;
  xra_cpu_st_e st_reg;
  xra_op_e op_reg;
  logic pend_reg;
  logic wr_reg;
  logic [7:0] ctl_reg;

  // one sequence at a time; each step: one request, then its answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= H_IDLE;
      op_reg <= OP_MOVE;
      {pend_reg, wr_reg} <= 2'h0;
      ctl_reg <= 8'h00;
      {cmd_ready, rsp_valid, irq_hold} <= 3'h0;
      rsp_data <= 8'h00;
      {dev.mv_req, dev.mv_wr, dev.mv_wide} <= 3'h0;
      dev.mv_addr <= 16'h0000;
      dev.mv_wdata <= 8'h00;
      {dev.sfr_req, dev.sfr_wr} <= 2'h0;
      dev.sfr_addr <= 8'h00;
      dev.sfr_wdata <= 8'h00;
    end else begin
      dev.mv_req <= 1'b0;
      dev.sfr_req <= 1'b0;
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      case (st_reg)
        H_IDLE: begin
          cmd_ready <= !cmd_valid;
          if (cmd_valid && cmd_ready) begin
            op_reg <= cmd_op;
            wr_reg <= cmd_wr;
            dev.mv_addr <= cmd_addr;
            dev.mv_wdata <= cmd_data;
            dev.sfr_addr <= cmd_addr[7:0];
            dev.sfr_wdata <= cmd_data;
            pend_reg <= 1'b1;
            if (cmd_op == OP_MOVE) begin
              dev.mv_req <= 1'b1;
              dev.mv_wr <= cmd_wr;
              dev.mv_wide <= cmd_wide;
              st_reg <= H_RAW;
            end else if (cmd_op == OP_SFR) begin
              dev.sfr_req <= 1'b1;
              dev.sfr_wr <= cmd_wr;
              st_reg <= H_RAW;
            end else begin
              pend_reg <= 1'b0;
              irq_hold <= 1'b1;
              st_reg <= H_POLL;
            end
          end
        end
        H_RAW: begin
          if (dev.mv_ack || dev.sfr_ack) begin
            pend_reg <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data <= dev.mv_ack ? dev.mv_rdata : dev.sfr_rdata;
            st_reg <= H_IDLE;
          end
        end
        H_POLL: begin
          if (!pend_reg) begin
            dev.sfr_req <= 1'b1;
            dev.sfr_wr <= 1'b0;
            dev.sfr_addr <= `XRA_NV_CTL_ADDR;
            pend_reg <= 1'b1;
          end else if (dev.sfr_ack) begin
            pend_reg <= 1'b0;
            // lockout released and idle, else read again
            if (dev.sfr_rdata[`XRA_CTL_INHIBIT] && !dev.sfr_rdata[`XRA_CTL_BUSY]) begin
              ctl_reg <= dev.sfr_rdata;
              st_reg <= H_MAP;
            end
          end
        end
        H_MAP: begin
          if (!pend_reg) begin
            dev.sfr_req <= 1'b1;
            dev.sfr_wr <= 1'b1;
            dev.sfr_wdata <= ctl_reg | (8'h01 << `XRA_CTL_MAP);
            pend_reg <= 1'b1;
          end else if (dev.sfr_ack) begin
            pend_reg <= 1'b0;
            st_reg <= H_MOVE;
          end
        end
        H_MOVE: begin
          if (!pend_reg) begin
            dev.mv_req <= 1'b1;
            dev.mv_wide <= 1'b1;
            dev.mv_wr <= (op_reg == OP_NV_WR);
            pend_reg <= 1'b1;
          end else if (dev.mv_ack) begin
            pend_reg <= 1'b0;
            rsp_data <= dev.mv_rdata;
            st_reg <= H_UNMAP;
          end
        end
        H_UNMAP: begin
          if (!pend_reg) begin
            dev.sfr_req <= 1'b1;
            dev.sfr_wr <= 1'b1;
            dev.sfr_wdata <= ctl_reg & ~(8'h01 << `XRA_CTL_MAP);
            pend_reg <= 1'b1;
          end else if (dev.sfr_ack) begin
            pend_reg <= 1'b0;
            rsp_valid <= 1'b1;
            irq_hold <= 1'b0;
            st_reg <= H_IDLE;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
endmodule : xra_cpu_end

// [xra_link_asserts.sv]
// concurrent checks on the cpu-to-decoder link
`timescale 1ns/1ps
`include "xra_cfg.svh"
module xra_link_asserts (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic mv_req, // move request
  input wire logic mv_wide, // wide pointer
  input wire logic [15:0] mv_addr, // move address
  input wire logic mv_ack, // move answer
  input wire logic [7:0] mv_rdata, // move read data
  input wire logic sfr_req, // sfr request
  input wire logic sfr_wr, // sfr write
  input wire logic [7:0] sfr_addr, // sfr address
  input wire logic [7:0] sfr_wdata, // sfr write data
  input wire logic sfr_ack, // sfr answer
  input wire logic [7:0] sfr_rdata // sfr read data
);
  logic [7:0] page_sh, aux_sh;
  logic map_sh, pgl_sh, rd_page, rd_ctl, ram_nar, ram_wid, nv_hit;
  logic [3:0] n_pages;
  // shadow of the routing registers, from link writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_sh <= `XRA_PAGE_RST;
      aux_sh <= `XRA_AUX_RST;
      {map_sh, pgl_sh} <= 2'b00;
    end else if (sfr_req && sfr_wr) begin
      if (sfr_addr == `XRA_PAGE_SEL_ADDR) page_sh <= sfr_wdata;
      if (sfr_addr == `XRA_AUX_CTL_ADDR) aux_sh <= sfr_wdata;
      if (sfr_addr == `XRA_NV_CTL_ADDR) {pgl_sh, map_sh} <= {sfr_wdata[`XRA_CTL_PGLOAD], sfr_wdata[`XRA_CTL_MAP]};
    end
  end
  // which register the pending read targets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {rd_page, rd_ctl} <= 2'b00;
    end else begin
      rd_page <= sfr_req && !sfr_wr && sfr_addr == `XRA_PAGE_SEL_ADDR;
      rd_ctl <= sfr_req && !sfr_wr && sfr_addr == `XRA_NV_CTL_ADDR;
    end
  end
  // ram pages per size code; reserved codes are full size
  assign n_pages = aux_sh[4:2] == 3'h4 ? 4'h7 : aux_sh[4:2] > 3'h4 ? 4'h8 : {1'b0, aux_sh[4:2]} + 4'h1;
  assign ram_nar = !mv_wide && !aux_sh[`XRA_AUX_BYPASS] && page_sh < {4'h0, n_pages};
  assign ram_wid = mv_wide && !map_sh && !aux_sh[`XRA_AUX_BYPASS] && mv_addr[15:8] < {4'h0, n_pages};
  assign nv_hit = mv_wide && map_sh && !aux_sh[`XRA_AUX_BYPASS] && mv_addr <= `XRA_NV_TOP;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_SFR_ACK: assert property (sfr_req |=> sfr_ack)
    else $error("no sfr answer");
  AST_PAGE_RD: assert property (sfr_ack && rd_page |-> sfr_rdata == page_sh)
    else $error("page readback");
  AST_CTL_RD: assert property (sfr_ack && rd_ctl |-> sfr_rdata[7] &&
    sfr_rdata[`XRA_CTL_MAP] == map_sh && sfr_rdata[`XRA_CTL_PGLOAD] == pgl_sh)
    else $error("control readback");
  AST_MOVE_MIN: assert property (mv_req |=> !mv_ack)
    else $error("move answer early");
  AST_ACK_PULSE: assert property ($rose(mv_ack) |=> !mv_ack)
    else $error("answer too long");
  AST_RAM_NARROW: assert property (mv_req && ram_nar |-> ##2 mv_ack)
    else $error("narrow ram late");
  AST_RAM_WIDE: assert property (mv_req && ram_wid |=> !mv_ack ##1 mv_ack)
    else $error("wide ram late");
  AST_NV_ACK: assert property (mv_req && nv_hit |-> ##2 mv_ack)
    else $error("store move late");
  AST_RDATA_HOLD: assert property (!mv_ack |-> $stable(mv_rdata))
    else $error("read data moved");
endmodule : xra_link_asserts

// [xra_bench.sv]
// bench: both ends joined, routing model, external memory stub
`timescale 1ns/1ps
`include "xra_cfg.svh"
module xra_bench;
  import xra_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, brownout = 1'b0, cmd_valid = 1'b0;
  xra_op_e cmd_op = OP_MOVE;
  logic cmd_wr = 1'b0, cmd_wide = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, irq_hold, ext_req, ext_wr, ext_hi_en;
  logic [7:0] rsp_data, ext_wdata;
  logic [15:0] ext_addr;
  logic ext_ack = 1'b0, ext_done = 1'b0, ext_hi_seen = 1'b0;
  logic [15:0] ext_addr_seen = 16'h0000;
  logic [7:0] ext_rdata = 8'h00;
  logic [7:0] ext_mem [logic [15:0]];
  logic [7:0] nv_m [int];
  logic [7:0] page_m = 8'h00;
  logic [7:0] aux_m = 8'h08;
  int ext_wait = 0, n_ext = 0, n_fail = 0, total_checks = 0;
  xra_if link();
  xra_device #(.LOCKOUT_CYC(20), .PROG_CYC(40)) u_xra_device (.clk(clk), .sys_rst(sys_rst), .cpu(link),
    .brownout(brownout), .ext_req(ext_req), .ext_wr(ext_wr), .ext_hi_en(ext_hi_en), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  xra_cpu_end u_xra_cpu_end (.clk(clk), .sys_rst(sys_rst), .dev(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wr(cmd_wr), .cmd_wide(cmd_wide), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq_hold(irq_hold));
  xra_link_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .mv_req(link.mv_req), .mv_wide(link.mv_wide),
    .mv_addr(link.mv_addr), .mv_ack(link.mv_ack), .mv_rdata(link.mv_rdata), .sfr_req(link.sfr_req),
    .sfr_wr(link.sfr_wr), .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata), .sfr_ack(link.sfr_ack),
    .sfr_rdata(link.sfr_rdata));
  always #12.5 clk = ~clk;
  // external memory stub: random wait, stale data scrambled
  always @(posedge clk) begin
    if (ext_req && !ext_done && ext_wait == 0) begin
      ext_ack <= 1'b1;
      ext_done <= 1'b1;
      ext_wait <= int'($urandom_range(3));
      ext_rdata <= ext_mem.exists(ext_addr) ? ext_mem[ext_addr] : 8'h5a;
      if (ext_wr) ext_mem[ext_addr] = ext_wdata;
      ext_hi_seen <= ext_hi_en;
      ext_addr_seen <= ext_addr;
      n_ext <= n_ext + 1;
    end else begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      ext_done <= ext_done && ext_req;
      if (ext_req && !ext_done) ext_wait <= ext_wait - 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // one command, held until taken; bounded wait for the response
  task automatic run(input xra_op_e op, input logic wr, input logic wide, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_wr <= wr;
    cmd_wide <= wide;
    cmd_addr <= a;
    cmd_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    q = rsp_data;
    if (n >= 3000) chk("response", 16'h0000, 16'h0001);
  endtask : run
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    run(OP_SFR, 1'b1, 1'b0, {8'h00, a}, d, q);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] q);
    run(OP_SFR, 1'b0, 1'b0, {8'h00, a}, 8'h00, q);
  endtask : sfr_rd
  function automatic int pages(input logic [7:0] aux);
    return aux[4:2] == 3'h4 ? 7 : aux[4:2] > 3'h4 ? 8 : int'(aux[4:2]) + 1;
  endfunction : pages
  // write and read back; model predicts ram or external
  task automatic move_pair(input logic wide, input logic [15:0] a);
    logic [7:0] d, q;
    int f, n0;
    bit ext;
    d = 8'($urandom);
    n0 = n_ext;
    f = wide ? int'(a) : int'({page_m[2:0], a[7:0]});
    ext = aux_m[1] || (!wide && page_m >= `XRA_NARROW_PAGES) || f >= 256 * pages(aux_m);
    run(OP_MOVE, 1'b1, wide, a, d, q);
    run(OP_MOVE, 1'b0, wide, a, 8'h00, q);
    chk("move data", q, d);
    chk("ext count", 16'(n_ext - n0), ext ? 16'h0002 : 16'h0000);
    if (ext) chk("ext addr", ext_addr_seen, wide ? a : {8'h00, a[7:0]});
    if (ext) chk("ext high", 16'(ext_hi_seen), 16'(wide));
  endtask : move_pair
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 16'h0000, 16'h0001);
    conclude();
  end
  initial begin
    logic [7:0] q, d;
    logic [7:0] pg [6];
    logic [11:0] na;
    logic [15:0] pa [$];
    void'($urandom(32'he56ac483));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    sfr_rd(`XRA_NV_CTL_ADDR, q);
    chk("ctl reset", q, 8'h80);
    sfr_rd(`XRA_PAGE_SEL_ADDR, q);
    chk("page reset", q, `XRA_PAGE_RST);
    sfr_rd(`XRA_AUX_CTL_ADDR, q);
    chk("aux reset", q, `XRA_AUX_RST);
    sfr_wr(8'h81, 8'h5a);
    sfr_rd(8'h81, q);
    chk("unmapped", q, 8'h00);
    $display("test registers done");
    pg = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'hff};
    foreach (pg[i]) begin
      sfr_wr(`XRA_PAGE_SEL_ADDR, pg[i]);
      page_m = pg[i];
      sfr_rd(`XRA_PAGE_SEL_ADDR, q);
      chk("page", q, pg[i]);
      move_pair(1'b0, 16'($urandom));
    end
    sfr_wr(`XRA_PAGE_SEL_ADDR, 8'h00);
    page_m = 8'h00;
    move_pair(1'b1, 16'h02ff);
    move_pair(1'b1, 16'h0300);
    aux_m = 8'h14;
    sfr_wr(`XRA_AUX_CTL_ADDR, aux_m);
    move_pair(1'b1, 16'($urandom_range(2047)));
    move_pair(1'b1, 16'($urandom_range(65535, 2048)));
    aux_m = 8'h16;
    sfr_wr(`XRA_AUX_CTL_ADDR, aux_m);
    move_pair(1'b1, 16'h0010);
    move_pair(1'b0, 16'h0010);
    aux_m = `XRA_AUX_RST;
    sfr_wr(`XRA_AUX_CTL_ADDR, aux_m);
    $display("test moves done");
    na = 12'($urandom);
    d = 8'($urandom);
    run(OP_NV_WR, 1'b1, 1'b1, {4'h0, na}, d, q);
    nv_m[na] = d;
    sfr_rd(`XRA_NV_CTL_ADDR, q);
    chk("busy", 16'(q[`XRA_CTL_BUSY]), 16'h0001);
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h02);
    run(OP_MOVE, 1'b0, 1'b1, {4'h0, na}, 8'h00, q);
    chk("busy read", q, `XRA_REFUSED_DATA);
    move_pair(1'b0, 16'($urandom));
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h00);
    run(OP_NV_RD, 1'b0, 1'b1, {4'h0, na}, 8'h00, q);
    chk("store", q, d);
    chk("irq", 16'(irq_hold), 16'h0000);
    $display("test store done");
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h22);
    for (int k = 1; k < 6; k++) begin
      if (k == 5) begin
        sfr_rd(`XRA_NV_CTL_ADDR, q);
        chk("load only", 16'(q[`XRA_CTL_BUSY]), 16'h0000);
        sfr_wr(`XRA_NV_CTL_ADDR, 8'h02);
      end
      pa.push_back({4'h0, na[11:5], 5'(na[4:0] + 5'(k))});
      run(OP_MOVE, 1'b1, 1'b1, pa[$], 8'(k * 37), q);
    end
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h00);
    pa.push_front({4'h0, na});
    foreach (pa[i]) begin
      run(OP_NV_RD, 1'b0, 1'b1, pa[i], 8'h00, q);
      chk("page data", q, i == 0 ? nv_m[na] : 8'(i * 37));
    end
    $display("test page done");
    run(OP_NV_WR, 1'b1, 1'b1, {4'h0, na}, ~d, q);
    brownout <= 1'b1;
    repeat (6) @(posedge clk);
    brownout <= 1'b0;
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h06);
    run(OP_MOVE, 1'b1, 1'b1, {4'h0, na}, ~d, q);
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h04);
    run(OP_NV_RD, 1'b0, 1'b1, {4'h0, na}, 8'h00, q);
    chk("no write", q, nv_m[na]);
    sfr_rd(`XRA_NV_CTL_ADDR, q);
    chk("error", 16'(q[`XRA_CTL_ERR]), 16'h0001);
    sfr_wr(`XRA_NV_CTL_ADDR, 8'h00);
    sfr_rd(`XRA_NV_CTL_ADDR, q);
    chk("error clear", 16'(q[`XRA_CTL_ERR]), 16'h0000);
    $display("test brownout done");
    conclude();
  end
endmodule : xra_bench
